/* rtl/programmable_lut_array.sv */
// Eight lookup cells with input routing and their configuration registers.
`timescale 1ns/1ps
module programmable_lut_array (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [lut_pkg::ADDR_WIDTH-1:0] addr,
	input wire logic [lut_pkg::DATA_WIDTH-1:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [lut_pkg::DATA_WIDTH-1:0] rdata,
	input wire logic du_output,
	input wire logic [lut_pkg::NUM_CELLS-1:0] mux_output,
	input wire logic [lut_pkg::NUM_CELLS-1:0] port_input,
	output logic [lut_pkg::NUM_CELLS-1:0] cell_output
);
	localparam int N = lut_pkg::NUM_CELLS;
	localparam int GW = lut_pkg::GROUP_WIDTH;
	localparam int SW = lut_pkg::SEL_WIDTH;
	localparam int DW = lut_pkg::DATA_WIDTH;

	// ----------------------------------------------------------------------
	// Register bus decode
	// ----------------------------------------------------------------------
	logic [2:0] region;
	logic [2:0] index;
	logic aligned;

	assign region = addr[7:5];
	assign index = addr[4:2];
	assign aligned = addr[1:0] == lut_pkg::WORD_ALIGN;

	lut_pkg::cell_cfg_s cfg_q [N];
	lut_pkg::cell_sel_s sel_q [N];
	logic fabric_en_q;
	logic [N-1:0] state_vec;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < N; i++) begin
				cfg_q[i] <= lut_pkg::CFG_RESET;
			end
		end else if (wr_en && aligned && region == lut_pkg::REGION_CTRL) begin
			cfg_q[index].truth <= wdata[lut_pkg::TRUTH_LSB +:
				lut_pkg::TRUTH_W];
			cfg_q[index].cell_operation_code <= lut_pkg::cell_opc_e'(
				wdata[lut_pkg::OPC_LSB +: lut_pkg::OPC_W]);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < N; i++) begin
				sel_q[i] <= lut_pkg::SEL_RESET;
			end
		end else if (wr_en && aligned && region == lut_pkg::REGION_SEL) begin
			sel_q[index].first <= wdata[lut_pkg::SEL_FIRST_LSB +: SW];
			sel_q[index].second <= wdata[lut_pkg::SEL_SECOND_LSB +: SW];
			sel_q[index].third <= wdata[lut_pkg::SEL_THIRD_LSB +: SW];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fabric_en_q <= lut_pkg::FABRIC_EN_RESET;
		end else if (wr_en && aligned && region == lut_pkg::REGION_MISC
			&& index == lut_pkg::MISC_FABRIC) begin
			fabric_en_q <= wdata[lut_pkg::FABRIC_EN_BIT];
		end
	end

	// ----------------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------------
	logic [DW-1:0] rdata_d;

	// Unmapped and misaligned reads answer zero.
	always_comb begin
		rdata_d = '0;
		if (aligned) begin
			unique case (region)
				lut_pkg::REGION_CTRL: begin
					rdata_d[lut_pkg::TRUTH_LSB +: lut_pkg::TRUTH_W] =
						cfg_q[index].truth;
					rdata_d[lut_pkg::OPC_LSB +: lut_pkg::OPC_W] = cfg_q[index].cell_operation_code;
				end
				lut_pkg::REGION_SEL: begin
					rdata_d[lut_pkg::SEL_FIRST_LSB +: SW] = sel_q[index].first;
					rdata_d[lut_pkg::SEL_SECOND_LSB +: SW] = sel_q[index].second;
					rdata_d[lut_pkg::SEL_THIRD_LSB +: SW] = sel_q[index].third;
				end
				lut_pkg::REGION_MISC: begin
					if (index == lut_pkg::MISC_FABRIC) begin
						rdata_d[lut_pkg::FABRIC_EN_BIT] = fabric_en_q;
					end else if (index == lut_pkg::MISC_STATUS) begin
						rdata_d[lut_pkg::STATUS_OUT_LSB +: N] = cell_output;
						rdata_d[lut_pkg::STATUS_STATE_LSB +: N] = state_vec;
					end
				end
				default: begin
					rdata_d = '0;
				end
			endcase
		end
	end

	// Read data stand for exactly the cycle after the strobe.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else if (rd_en) begin
			rdata <= rdata_d;
		end else begin
			rdata <= '0;
		end
	end

	// ----------------------------------------------------------------------
	// Input synchronisers and cell reset
	// ----------------------------------------------------------------------
	logic [N-1:0] mux_sync;
	logic [N-1:0] port_sync;
	logic cell_rst_n;

	input_sync #(
		.WIDTH(2 * N)
	) u_input_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.async_in({port_input, mux_output}),
		.sync_out({port_sync, mux_sync})
	);

	// The enable is itself a flop, so this combined reset cannot glitch.
	assign cell_rst_n = rst_n & fabric_en_q;

	// ----------------------------------------------------------------------
	// Cells and input routing
	// ----------------------------------------------------------------------
	// A combinational cell that selects its own output forms a loop; software
	// must register one cell in any such ring.
	function automatic logic route(input logic [SW-1:0] code,
		input logic low_src, input logic [N-1:0] outs,
		input logic [GW-1:0] mux_grp, input logic [GW-1:0] port_grp);
		logic bit_out;
		bit_out = 1'b0;
		if (code >= lut_pkg::SEL_PORT_BASE) begin
			bit_out = port_grp[code[1:0]];
		end else if (code >= lut_pkg::SEL_MUX_BASE) begin
			bit_out = mux_grp[code[1:0]];
		end else if (code == '0) begin
			bit_out = low_src;
		end else begin
			bit_out = outs[code[2:0]];
		end
		return bit_out;
	endfunction

	logic [N-1:0] in_first;
	logic [N-1:0] in_second;
	logic [N-1:0] in_third;

	for (genvar c = 0; c < N; c++) begin : g_cell
		localparam int G = (c / GW) * GW;

		assign in_first[c] = route(sel_q[c].first, du_output, cell_output,
			mux_sync[G +: GW], port_sync[G +: GW]);
		assign in_second[c] = route(sel_q[c].second, cell_output[0],
			cell_output, mux_sync[G +: GW], port_sync[G +: GW]);
		assign in_third[c] = route(sel_q[c].third, cell_output[0],
			cell_output, mux_sync[G +: GW], port_sync[G +: GW]);

		lut_cell u_cell (
			.sys_clk(sys_clk),
			.cell_rst_n(cell_rst_n),
			.cfg(cfg_q[c]),
			.first_cell_input(in_first[c]),
			.second_cell_input(in_second[c]),
			.third_cell_input(in_third[c]),
			.cell_output(cell_output[c]),
			.state_q(state_vec[c])
		);
	end

	// ----------------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence ctrl_write_s;
		wr_en && aligned && region == lut_pkg::REGION_CTRL;
	endsequence

	sequence ctrl_read_s;
		rd_en && aligned && region == lut_pkg::REGION_CTRL;
	endsequence

	sequence sel_write_s;
		wr_en && aligned && region == lut_pkg::REGION_SEL;
	endsequence

	sequence sel_read_s;
		rd_en && aligned && region == lut_pkg::REGION_SEL;
	endsequence

	sequence status_read_s;
		rd_en && aligned && region == lut_pkg::REGION_MISC
		&& index == lut_pkg::MISC_STATUS;
	endsequence

	// The read is checked against the vector as it stood at the strobe, so a
	// write in the same cycle does not upset it.
	ctrl_readback_a: assert property (
		ctrl_read_s |=> rdata[lut_pkg::TRUTH_LSB +: lut_pkg::TRUTH_W]
		== $past(cfg_q[index].truth)
	) else $error("control read did not return truth vector");

	opc_store_a: assert property (
		ctrl_write_s |=> cfg_q[$past(index)].cell_operation_code
		== $past(wdata[lut_pkg::OPC_LSB +: lut_pkg::OPC_W])
	) else $error("operation code not stored from write");

	disabled_clear_a: assert property (
		!fabric_en_q |=> state_vec == '0
	) else $error("cell state not cleared while disabled");

	first_du_a: assert property (
		sel_q[0].first == '0 |-> in_first[0] == du_output
	) else $error("first selector code zero is not data unit");

	second_cell0_a: assert property (
		sel_q[5].second == '0 |-> in_second[5] == cell_output[0]
	) else $error("second selector code zero is not cell zero");

	third_mux_a: assert property (
		sel_q[6].third == lut_pkg::SEL_MUX_BASE |-> in_third[6] == mux_sync[GW]
	) else $error("upper group multiplexer bit misrouted");

	first_port_a: assert property (
		sel_q[1].first == lut_pkg::SEL_PORT_BASE |-> in_first[1] == port_sync[0]
	) else $error("lower group port bit misrouted");

	read_one_cycle_a: assert property (
		!rd_en |=> rdata == '0
	) else $error("read data outlived its cycle");

	misaligned_read_a: assert property (
		rd_en && !aligned |=> rdata == '0
	) else $error("misaligned read returned data");

	truth_store_a: assert property (
		ctrl_write_s |=> cfg_q[$past(index)].truth
		== $past(wdata[lut_pkg::TRUTH_LSB +: lut_pkg::TRUTH_W])
	) else $error("truth vector not stored from write");

	sel_store_a: assert property (
		sel_write_s |=> sel_q[$past(index)].first
		== $past(wdata[lut_pkg::SEL_FIRST_LSB +: SW])
	) else $error("first selector not stored from write");

	sel_readback_a: assert property (
		sel_read_s |=> rdata[lut_pkg::SEL_THIRD_LSB +: SW]
		== $past(sel_q[index].third)
	) else $error("select read did not return third selector");

	status_read_a: assert property (
		status_read_s |=> rdata[lut_pkg::STATUS_STATE_LSB +: N]
		== $past(state_vec)
	) else $error("status read did not return cell states");

	cell_reset_a: assert property (
		!cell_rst_n |-> state_vec == '0
	) else $error("cell state not held clear in reset");

	first_cell_a: assert property (
		sel_q[2].first == 4'h1 |-> in_first[2] == cell_output[1]
	) else $error("first selector code one is not cell one");

	first_mux_a: assert property (
		sel_q[3].first == lut_pkg::SEL_MUX_BASE |-> in_first[3] == mux_sync[0]
	) else $error("lower group multiplexer bit misrouted");

	second_cell_a: assert property (
		sel_q[5].second == 4'h3 |-> in_second[5] == cell_output[3]
	) else $error("second selector code three is not cell three");

	second_port_a: assert property (
		sel_q[4].second == lut_pkg::SEL_PORT_BASE
		|-> in_second[4] == port_sync[GW]
	) else $error("upper group port bit misrouted");

	third_cell0_a: assert property (
		sel_q[7].third == '0 |-> in_third[7] == cell_output[0]
	) else $error("third selector code zero is not cell zero");
endmodule // programmable_lut_array

/* rtl/lut_pkg.sv */
// Constants, field layouts and types shared by the lookup-cell fabric.
//
// Function
// - The fabric has eight independent cells, each a three-input lookup plus one flip-flop.
// - A cell indexes its 8-bit truth vector, control bits [7:0], with its three selected inputs; in feedback mode the stored state replaces the first.
// - A 2-bit operation code in control bits [9:8] sets how the cell flip-flop is used.
// - Output and next state come from the code, the stored state, the inputs and the vector.
// - Each cell has its own select register choosing its three inputs independently.
// - First selector bits [3:0]: code 0 is the data-unit output, codes 1-7 that cell's output.
// - Second selector bits [11:8]: codes 0-7 are the output of the cell with that number.
// - Third selector bits [19:16] maps codes exactly as the second selector does.
// - Codes 8-11 pick multiplexer bits 0-3 in cells 0-3 and bits 4-7 in cells 4-7.
// - Codes 12-15 pick port input bits 0-3 in cells 0-3 and bits 4-7 in cells 4-7.
// - Cell flip-flops run on the block clock shared with the synchronisers and data unit.
// - While reset is active or the fabric is disabled, every cell flip-flop is cleared to zero.
package lut_pkg;

	localparam int NUM_CELLS = 8;
	localparam int GROUP_WIDTH = 4;
	localparam int SEL_WIDTH = 4;
	localparam int ADDR_WIDTH = 8;
	localparam int DATA_WIDTH = 32;

	// ----------------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------------
	localparam logic [2:0] REGION_CTRL = 3'h0;
	localparam logic [2:0] REGION_SEL = 3'h1;
	localparam logic [2:0] REGION_MISC = 3'h2;
	localparam logic [2:0] MISC_FABRIC = 3'h0;
	localparam logic [2:0] MISC_STATUS = 3'h1;
	localparam logic [1:0] WORD_ALIGN = 2'h0;

	// ----------------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------------
	localparam int TRUTH_LSB = 0;
	localparam int TRUTH_W = 8;
	localparam int OPC_LSB = 8;
	localparam int OPC_W = 2;
	localparam int SEL_FIRST_LSB = 0;
	localparam int SEL_SECOND_LSB = 8;
	localparam int SEL_THIRD_LSB = 16;
	localparam int FABRIC_EN_BIT = 0;
	localparam int STATUS_OUT_LSB = 0;
	localparam int STATUS_STATE_LSB = 8;

	// ----------------------------------------------------------------------
	// Types and reset values
	// ----------------------------------------------------------------------
	typedef enum logic [1:0] {
		OPC_COMB = 2'h0,
		OPC_REG = 2'h1,
		OPC_FEEDBACK = 2'h2,
		OPC_TOGGLE = 2'h3
	} cell_opc_e;

	typedef struct packed {
		cell_opc_e cell_operation_code;
		logic [TRUTH_W-1:0] truth;
	} cell_cfg_s;

	typedef struct packed {
		logic [SEL_WIDTH-1:0] third;
		logic [SEL_WIDTH-1:0] second;
		logic [SEL_WIDTH-1:0] first;
	} cell_sel_s;

	localparam cell_cfg_s CFG_RESET = '{cell_operation_code: OPC_COMB, truth: 8'h00};
	localparam cell_sel_s SEL_RESET = '{third: 4'h0, second: 4'h0, first: 4'h0};
	localparam logic FABRIC_EN_RESET = 1'b0;
	localparam logic [SEL_WIDTH-1:0] SEL_MUX_BASE = 4'h8;
	localparam logic [SEL_WIDTH-1:0] SEL_PORT_BASE = 4'hC;

endpackage

/* rtl/input_sync.sv */
// Two-flop synchroniser for the multiplexer and port input bits.
`timescale 1ns/1ps
module input_sync #(
	parameter int WIDTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	// The first stage feeds only the second stage.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // input_sync

/* rtl/lut_cell.sv */
// One three-input lookup cell with its storage flip-flop.
`timescale 1ns/1ps
module lut_cell (
	input wire logic sys_clk,
	input wire logic cell_rst_n,
	input wire lut_pkg::cell_cfg_s cfg,
	input wire logic first_cell_input,
	input wire logic second_cell_input,
	input wire logic third_cell_input,
	output logic cell_output,
	output logic state_q
);
	logic lut_bit;
	logic fb_bit;
	logic state_d;

	assign lut_bit = cfg.truth[{third_cell_input, second_cell_input,
		first_cell_input}];
	assign fb_bit = cfg.truth[{third_cell_input, second_cell_input, state_q}];

	always_comb begin
		unique case (cfg.cell_operation_code)
			lut_pkg::OPC_COMB: begin
				cell_output = lut_bit;
				state_d = state_q;
			end
			lut_pkg::OPC_REG: begin
				cell_output = state_q;
				state_d = lut_bit;
			end
			lut_pkg::OPC_FEEDBACK: begin
				cell_output = fb_bit;
				state_d = fb_bit;
			end
			lut_pkg::OPC_TOGGLE: begin
				cell_output = state_q;
				state_d = state_q ^ lut_bit;
			end
		endcase
	end

	// Cleared asynchronously by reset or by a disabled fabric.
	always_ff @(posedge sys_clk or negedge cell_rst_n) begin
		if (!cell_rst_n) begin
			state_q <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!cell_rst_n);

	comb_output_a: assert property (
		cfg.cell_operation_code == lut_pkg::OPC_COMB |-> cell_output == lut_bit
	) else $error("combinational cell output differs from truth bit");

	reg_capture_a: assert property (
		cfg.cell_operation_code == lut_pkg::OPC_REG ##1 cfg.cell_operation_code == lut_pkg::OPC_REG
		|-> cell_output == $past(lut_bit)
	) else $error("registered cell output is not last truth bit");

	toggle_step_a: assert property (
		cfg.cell_operation_code == lut_pkg::OPC_TOGGLE |=> state_q == ($past(state_q)
		^ $past(lut_bit))
	) else $error("toggle cell did not flip on truth bit");
endmodule // lut_cell

/* bench/pin_side_model.sv */
// Pin-side model: multiplexer outputs and port pins as free levels.
`timescale 1ns/1ps
module pin_side_model (
	input wire logic sys_clk,
	input wire logic run,
	output logic [7:0] mux_output,
	output logic [7:0] port_input
);
	initial begin
		mux_output = 8'h00;
		port_input = 8'h00;
	end
	// Levels move only while run is high, so the bench can let the
	// synchronisers settle before it starts tracking them.
	always @(posedge sys_clk) begin
		if (run) begin
			mux_output <= 8'($urandom);
			port_input <= 8'($urandom);
		end
	end
endmodule // pin_side_model

/* bench/programmable_lut_array_tb.sv */
// Self-checking bench for the lookup-cell fabric.
`timescale 1ns/1ps
module programmable_lut_array_tb;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic du_output = 1'b0;
	logic run = 1'b0;
	logic [7:0] mux_output, port_input, cell_output;
	logic [7:0] pm1, pm2, pp1, pp2;
	int n_fail = 0;
	int comparisons = 0;
	int tr[8], cell_operation_code[8], fs[8][3];
	bit st[8], o[8];

	programmable_lut_array u_programmable_lut_array (.sys_clk, .rst_n,
		.addr, .wdata, .wr_en, .rd_en, .rdata, .du_output, .mux_output,
		.port_input, .cell_output);
	pin_side_model u_pin_side_model (.sys_clk, .run, .mux_output,
		.port_input);

	initial forever #4 sys_clk = ~sys_clk;

	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask

	task automatic rd(logic [7:0] a, logic [31:0] exp);
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		@(negedge sys_clk);
		check($sformatf("rdata at %h", a), exp, rdata);
	endtask

	// ------------------------------------------------------------------
	// Cell model
	// ------------------------------------------------------------------
	function automatic bit src(int y, int c, bit first);
		int g;
		g = (y / 4) * 4 + c % 4;
		if (c >= 12) return pp2[g];
		if (c >= 8) return pm2[g];
		if (first && c == 0) return du_output;
		return o[c];
	endfunction

	// Cells only ever read lower-numbered cells, so one ordered pass
	// settles every combinational chain.
	task automatic step(bit en);
		bit a, b, c;
		bit n[8];
		for (int y = 0; y < 8; y++) begin
			a = src(y, fs[y][0], 1'b1);
			b = src(y, fs[y][1], 1'b0);
			c = src(y, fs[y][2], 1'b0);
			case (cell_operation_code[y])
			0: begin
				o[y] = tr[y][{c, b, a}];
				n[y] = st[y];
			end
			1: begin
				o[y] = st[y];
				n[y] = tr[y][{c, b, a}];
			end
			2: begin
				o[y] = tr[y][{c, b, st[y]}];
				n[y] = o[y];
			end
			default: begin
				o[y] = st[y];
				n[y] = st[y] ^ tr[y][{c, b, a}];
			end
			endcase
			check($sformatf("cell_output %0d", y), 32'(o[y]),
				32'(cell_output[y]));
		end
		for (int y = 0; y < 8; y++) st[y] = en & n[y];
		pm2 = pm1;
		pm1 = mux_output;
		pp2 = pp1;
		pp1 = port_input;
	endtask

	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	task automatic phase(bit en, int cycles);
		@(posedge sys_clk);
		run <= 1'b0;
		repeat (3) @(posedge sys_clk);
		wr(8'h40, {31'h0, en});
		for (int y = 0; y < 8; y++) st[y] = 1'b0;
		pm1 = mux_output;
		pm2 = mux_output;
		pp1 = port_input;
		pp2 = port_input;
		repeat (cycles) begin
			@(negedge sys_clk);
			step(en);
			@(posedge sys_clk);
			du_output <= 1'($urandom);
			run <= 1'b1;
		end
		$display("cell phase with enable %0d done", en);
	endtask

	task automatic setup(int r);
		logic [31:0] w;
		for (int y = 0; y < 8; y++) begin
			w = $urandom;
			w[9:8] = 2'((y + r) % 4);
			tr[y] = w[7:0];
			cell_operation_code[y] = w[9:8];
			wr(8'(4 * y), w);
			rd(8'(4 * y), w & 32'h000003FF);
			w = $urandom;
			for (int k = 0; k < 3; k++) begin
				fs[y][k] = w[8 * k +: 4];
				if (fs[y][k] < 8 && fs[y][k] >= y && !(k == 0 && fs[y][k] == 0))
					fs[y][k] += 8;
				w[8 * k +: 4] = 4'(fs[y][k]);
			end
			wr(8'(32 + 4 * y), w);
			rd(8'(32 + 4 * y), w & 32'h000F0F0F);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		void'($urandom(58643));
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 8; a++) begin
			rd(8'(4 * a), 32'h0);
			rd(8'(32 + 4 * a), 32'h0);
		end
		rd(8'h40, 32'h0);
		rd(8'h44, 32'h0);
		wr(8'h81, 32'hFFFFFFFF);
		rd(8'h80, 32'h0);
		wr(8'h01, 32'h000003FF);
		rd(8'h00, 32'h0);
		$display("register reset and map test done");
		for (int r = 0; r < 4; r++) begin
			phase(1'b0, 20);
			setup(r);
			phase(1'b1, 80);
		end
		summarize();
	end

	// Whole run is about 770 cycles; this leaves a wide margin.
	initial begin
		repeat (6000) @(posedge sys_clk);
		n_fail++;
		$display("watchdog expired");
		summarize();
	end
endmodule // programmable_lut_array_tb
